/* File: rtl/dcs_controller.sv */
// Memory controller end: spaces link commands by counted clock edges.
// Assumes the device end shares clk and samples the link on each edge.
`timescale 1ns/1ps
// How it works
// - Two idle cycles between write and read.
// - New clock-enable counts after three sampled edges.
// - Clock-enable held three edges before next change.
// - Faulted write is rewritten before reading it.
// - Picosecond times become rounded-up cycle counts.
// - Auto-precharge delay is recovery plus precharge cycles.
// - Mode bit ten picks single or differential strobe.
// - Activate two cycles after power-down exit registers.
// - Timing is counted in clock edges only.
module dcs_controller #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16,
  parameter int WR_NCK = dcs_pkg::WR_NCK_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reqValid,
  input dcs_pkg::dcs_cmd_e reqCmd,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqData,
  output logic reqReady,
  input wire logic wrFault,
  output logic rdValid,
  output logic [DATA_W-1:0] rdData,
  output logic poweredDown,
  output logic rewritePending,
  dcs_link_if.ctrl link
);

  // Auto-precharge write delay in counted edges.
  localparam int DAL_NCK = WR_NCK + dcs_pkg::TRP_NCK;
  // Edges from a raised clock-enable until activate may be issued.
  localparam int XP_LOAD = dcs_pkg::CKE_REG_NCK + dcs_pkg::XP_NCK - 2;

  // Every counter load must fit the shared counter width.
  generate
    if (ADDR_W <= dcs_pkg::STROBE_BIT || WR_NCK < 1 || DATA_W < 1 ||
        DAL_NCK >= (1 << dcs_pkg::CNT_W) ||
        XP_LOAD >= (1 << dcs_pkg::CNT_W) ||
        dcs_pkg::CKE_HOLD_NCK > (1 << dcs_pkg::CNT_W)) begin : g_bad
      $error("dcs_controller: parameters out of range");
    end
  endgenerate

  // The whole controller state; counters step toward zero on every edge.
  typedef struct packed {
    dcs_pkg::dcs_pwr_e pwr;
    logic cke;
    dcs_pkg::dcs_cnt_t hold;
    dcs_pkg::dcs_cnt_t wtr;
    dcs_pkg::dcs_cnt_t rp;
    dcs_pkg::dcs_cnt_t xp;
    dcs_pkg::dcs_cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dqOe_n;
    logic single;
    logic faultPend;
    logic [ADDR_W-1:0] faultAddr;
    logic [DATA_W-1:0] faultData;
    logic [ADDR_W-1:0] lastAddr;
    logic [DATA_W-1:0] lastData;
    logic rdValid;
    logic [DATA_W-1:0] rdData;
  } dcs_ctl_s;

  dcs_ctl_s st_q;
  dcs_ctl_s st_d;
  logic isUp;
  logic rewriteGo;
  logic allowed;
  logic issue;
  logic strobeSeen;

  // Both write kinds place data on the link and start the read gap.
  function automatic logic is_write(input dcs_pkg::dcs_cmd_e c);
    return c == dcs_pkg::CMD_WRITE || c == dcs_pkg::CMD_WRITE_AP;
  endfunction

  assign isUp = (st_q.pwr == dcs_pkg::PWR_UP);
  // The owed rewrite takes the link ahead of any user request.
  assign rewriteGo = st_q.faultPend && isUp && st_q.xp == '0;

  // Refusal is judged from registered state only, so a request that is
  // held steady sees the same answer until the edge that takes it.
  always_comb begin
    allowed = 1'h0;
    unique case (reqCmd)
      dcs_pkg::CMD_NOP: allowed = 1'h1;
      dcs_pkg::CMD_ACT: begin
        // Each dependent command waits for its own counter.
        allowed = isUp && st_q.xp == '0 && st_q.rp == '0;
      end
      dcs_pkg::CMD_READ: begin
        // A faulted location must be rewritten before it may be read.
        allowed = isUp && st_q.xp == '0 && st_q.wtr == '0 &&
                  !(st_q.faultPend && st_q.faultAddr == reqAddr);
      end
      dcs_pkg::CMD_WRITE, dcs_pkg::CMD_WRITE_AP, dcs_pkg::CMD_PRE,
      dcs_pkg::CMD_MODE: allowed = isUp && st_q.xp == '0;
      dcs_pkg::CMD_PD_ENTER: allowed = isUp && st_q.hold == '0;
      dcs_pkg::CMD_PD_EXIT: allowed = !isUp && st_q.hold == '0;
      default: allowed = 1'h0;
    endcase
  end

  assign reqReady = allowed && !rewriteGo;
  assign issue = reqValid && reqReady;
  // Read data is qualified by the strobe in the style in force.
  assign strobeSeen = !link.dqsOe_n &&
                      (st_q.single ? link.dqsP : (link.dqsP && !link.dqsN));

  always_comb begin
    st_d = st_q;
    st_d.hold = dcs_pkg::count_down(st_q.hold);
    st_d.wtr = dcs_pkg::count_down(st_q.wtr);
    st_d.rp = dcs_pkg::count_down(st_q.rp);
    st_d.xp = dcs_pkg::count_down(st_q.xp);
    st_d.cmd = dcs_pkg::CMD_NOP;
    st_d.dqOe_n = 1'h1;
    // Read data is taken on the edge at which the device strobe stands.
    st_d.rdValid = strobeSeen;
    if (strobeSeen) begin
      st_d.rdData = link.dqBus;
    end
    if (rewriteGo) begin
      st_d.cmd = dcs_pkg::CMD_WRITE;
      st_d.addr = st_q.faultAddr;
      st_d.dq = st_q.faultData;
      st_d.dqOe_n = 1'h0;
      st_d.faultPend = 1'h0;
      st_d.lastAddr = st_q.faultAddr;
      st_d.lastData = st_q.faultData;
      st_d.wtr = dcs_pkg::dcs_cnt_t'(dcs_pkg::WTR_NCK);
    end else if (issue) begin
      unique case (reqCmd)
        dcs_pkg::CMD_PD_ENTER: begin
          // Commands stop at once; the device follows after registration.
          st_d.cke = 1'h0;
          st_d.pwr = dcs_pkg::PWR_DOWN;
          st_d.hold = dcs_pkg::dcs_cnt_t'(dcs_pkg::CKE_HOLD_NCK - 1);
        end
        dcs_pkg::CMD_PD_EXIT: begin
          st_d.cke = 1'h1;
          st_d.pwr = dcs_pkg::PWR_UP;
          st_d.hold = dcs_pkg::dcs_cnt_t'(dcs_pkg::CKE_HOLD_NCK - 1);
          // Device takes the level only after three edges.
          st_d.xp = dcs_pkg::dcs_cnt_t'(XP_LOAD);
        end
        dcs_pkg::CMD_NOP: begin
        end
        default: begin
          st_d.cmd = reqCmd;
          st_d.addr = reqAddr;
          if (is_write(reqCmd)) begin
            st_d.dq = reqData;
            st_d.dqOe_n = 1'h0;
            st_d.lastAddr = reqAddr;
            st_d.lastData = reqData;
            st_d.wtr = dcs_pkg::dcs_cnt_t'(dcs_pkg::WTR_NCK);
          end
          if (reqCmd == dcs_pkg::CMD_WRITE_AP) begin
            st_d.rp = dcs_pkg::dcs_cnt_t'(DAL_NCK - 1);
          end
          if (reqCmd == dcs_pkg::CMD_PRE) begin
            st_d.rp = dcs_pkg::dcs_cnt_t'(dcs_pkg::TRP_NCK - 1);
          end
          if (reqCmd == dcs_pkg::CMD_MODE) begin
            st_d.single = reqAddr[dcs_pkg::STROBE_BIT];
          end
        end
      endcase
    end
    // A fault report wins over the rewrite being issued this cycle.
    if (wrFault) begin
      st_d.faultPend = 1'h1;
      st_d.faultAddr = st_q.lastAddr;
      st_d.faultData = st_q.lastData;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{pwr: dcs_pkg::PWR_UP, cke: 1'h1, cmd: dcs_pkg::CMD_NOP,
                dqOe_n: 1'h1, single: dcs_pkg::STROBE_SINGLE_RST,
                default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Link outputs come straight from flip-flops, as the device samples them.
  assign link.cke = st_q.cke;
  assign link.cmd = st_q.cmd;
  assign link.addr = st_q.addr;
  assign link.dqCtl = st_q.dq;
  assign link.dqCtlOe_n = st_q.dqOe_n;
  assign rdValid = st_q.rdValid;
  assign rdData = st_q.rdData;
  assign poweredDown = (st_q.pwr == dcs_pkg::PWR_DOWN);
  assign rewritePending = st_q.faultPend;

endmodule // dcs_controller

/* File: rtl/dcs_pkg.sv */
// Shared constants, command codes and helpers for both link ends.
// Assumes both ends run on one clock of period TCK_PS.
package dcs_pkg;

  localparam int TCK_PS = 4000;
  localparam int TRP_PS = 15000;
  localparam int WR_NCK_DEF = 5;
  localparam int WTR_NCK = 2;
  localparam int CKE_REG_NCK = 3;
  localparam int CKE_HOLD_NCK = 3;
  localparam int XP_NCK = 2;
  localparam int STROBE_BIT = 10;
  localparam logic STROBE_SINGLE_RST = 1'h0;
  localparam int CNT_W = 6;

  typedef logic [CNT_W-1:0] dcs_cnt_t;

  // Whole-cycle count of a time, rounded up.
  function automatic int ru_div(input int num, input int den);
    return (num + den - 1) / den;
  endfunction

  localparam int TRP_NCK = ru_div(TRP_PS, TCK_PS);

  // Counter step toward zero that never wraps.
  function automatic dcs_cnt_t count_down(input dcs_cnt_t val);
    return (val == '0) ? '0 : dcs_cnt_t'(val - 1'h1);
  endfunction

  typedef enum logic [8:0] {
    CMD_NOP      = 9'h001,
    CMD_ACT      = 9'h002,
    CMD_READ     = 9'h004,
    CMD_WRITE    = 9'h008,
    CMD_WRITE_AP = 9'h010,
    CMD_PRE      = 9'h020,
    CMD_MODE     = 9'h040,
    CMD_PD_ENTER = 9'h080,
    CMD_PD_EXIT  = 9'h100
  } dcs_cmd_e;

  typedef enum logic [1:0] {
    PWR_UP   = 2'h1,
    PWR_DOWN = 2'h2
  } dcs_pwr_e;

endpackage

/* File: rtl/dcs_link_if.sv */
// Memory link between controller end and device end.
// Two-way data is resolved here from the output enables.
`timescale 1ns/1ps
interface dcs_link_if #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16
);
  logic cke;
  dcs_pkg::dcs_cmd_e cmd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dqCtl;
  logic dqCtlOe_n;
  logic [DATA_W-1:0] dqDev;
  logic dqDevOe_n;
  logic [DATA_W-1:0] dqBus;
  logic dqsP;
  logic dqsN;
  logic dqsOe_n;

  assign dqBus = !dqCtlOe_n ? dqCtl : (!dqDevOe_n ? dqDev : '0);

  modport ctrl (
    output cke, cmd, addr, dqCtl, dqCtlOe_n,
    input dqBus, dqsP, dqsN, dqsOe_n
  );

  modport dev (
    input cke, cmd, addr, dqBus,
    output dqDev, dqDevOe_n, dqsP, dqsN, dqsOe_n
  );
endinterface

/* File: rtl/dcs_device.sv */
// Memory device end: clock-enable registration, spacing checks, storage.
// Assumes link inputs are synchronous to clk and change after its edge.
`timescale 1ns/1ps
module dcs_device #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16,
  parameter int MEM_AW = 6,
  parameter int WR_NCK = dcs_pkg::WR_NCK_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  dcs_link_if.dev link,
  output logic poweredDown,
  output logic strobeSingle,
  output logic timingErr
);

  localparam int DAL_NCK = WR_NCK + dcs_pkg::TRP_NCK;

  generate
    if (MEM_AW > ADDR_W || ADDR_W <= dcs_pkg::STROBE_BIT || WR_NCK < 1 ||
        DAL_NCK >= (1 << dcs_pkg::CNT_W)) begin : g_bad
      $error("dcs_device: parameters out of range");
    end
  endgenerate

  typedef struct packed {
    dcs_pkg::dcs_pwr_e pwr;
    logic ckeEff;
    logic [1:0] ckeRun;
    dcs_pkg::dcs_cnt_t xp;
    dcs_pkg::dcs_cnt_t rp;
    dcs_pkg::dcs_cnt_t wtr;
    logic single;
    logic err;
    logic [DATA_W-1:0] rdData;
    logic rdStrobe;
  } dcs_dev_s;

  dcs_dev_s st_q;
  dcs_dev_s st_d;
  logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];
  logic [MEM_AW-1:0] memAddr;

  assign memAddr = link.addr[MEM_AW-1:0];

  always_comb begin
    st_d = st_q;
    st_d.xp = dcs_pkg::count_down(st_q.xp);
    st_d.rp = dcs_pkg::count_down(st_q.rp);
    st_d.wtr = dcs_pkg::count_down(st_q.wtr);
    st_d.rdStrobe = 1'h0;
    // A new level counts only after three consecutive equal samples.
    if (link.cke != st_q.ckeEff) begin
      if (32'(st_q.ckeRun) + 1 == dcs_pkg::CKE_REG_NCK) begin
        st_d.ckeEff = link.cke;
        st_d.ckeRun = 2'h0;
        st_d.pwr = link.cke ? dcs_pkg::PWR_UP : dcs_pkg::PWR_DOWN;
        if (link.cke) begin
          st_d.xp = dcs_pkg::dcs_cnt_t'(dcs_pkg::XP_NCK - 1);
        end
      end else begin
        st_d.ckeRun = 2'(st_q.ckeRun + 2'h1);
      end
    end else begin
      st_d.ckeRun = 2'h0;
    end
    unique case (st_q.pwr)
      dcs_pkg::PWR_DOWN: begin
        if (link.cmd != dcs_pkg::CMD_NOP) begin
          st_d.err = 1'h1;
        end
      end
      dcs_pkg::PWR_UP: begin
        unique case (link.cmd)
          dcs_pkg::CMD_ACT: begin
            // Spacing is judged in counted edges only.
            if (st_q.xp != '0 || st_q.rp != '0) begin
              st_d.err = 1'h1;
            end
          end
          dcs_pkg::CMD_READ: begin
            if (st_q.wtr != '0) begin
              st_d.err = 1'h1;
            end
            st_d.rdData = mem[memAddr];
            st_d.rdStrobe = 1'h1;
          end
          dcs_pkg::CMD_WRITE: begin
            st_d.wtr = dcs_pkg::dcs_cnt_t'(dcs_pkg::WTR_NCK);
          end
          dcs_pkg::CMD_WRITE_AP: begin
            st_d.wtr = dcs_pkg::dcs_cnt_t'(dcs_pkg::WTR_NCK);
            st_d.rp = dcs_pkg::dcs_cnt_t'(DAL_NCK - 1);
          end
          dcs_pkg::CMD_PRE: begin
            st_d.rp = dcs_pkg::dcs_cnt_t'(dcs_pkg::TRP_NCK - 1);
          end
          dcs_pkg::CMD_MODE: begin
            st_d.single = link.addr[dcs_pkg::STROBE_BIT];
          end
          default: begin
          end
        endcase
      end
      default: begin
        st_d.pwr = dcs_pkg::PWR_UP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '{pwr: dcs_pkg::PWR_UP, ckeEff: 1'h1,
                single: dcs_pkg::STROBE_SINGLE_RST, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // Storage has no reset; contents are undefined until written.
  always_ff @(posedge clk) begin
    if (st_q.pwr == dcs_pkg::PWR_UP && (link.cmd == dcs_pkg::CMD_WRITE ||
        link.cmd == dcs_pkg::CMD_WRITE_AP)) begin
      mem[memAddr] <= link.dqBus;
    end
  end

  assign link.dqDev = st_q.rdData;
  assign link.dqDevOe_n = !st_q.rdStrobe;
  assign link.dqsOe_n = !st_q.rdStrobe;
  assign link.dqsP = st_q.rdStrobe;
  // Single-ended mode parks the complement low; differential drives its inverse.
  assign link.dqsN = st_q.single ? 1'h0 : !st_q.rdStrobe;
  assign poweredDown = (st_q.pwr == dcs_pkg::PWR_DOWN);
  assign strobeSingle = st_q.single;
  assign timingErr = st_q.err;

endmodule // dcs_device

/* File: sim/dcs_link_properties.sv */
// Concurrent checks on the link between controller and device ends.
// Assumes the signals of one dcs_link_if, sampled on the rising clk edge.
`timescale 1ns/1ps
module dcs_link_properties #(
  parameter int ADDR_W = 14
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cke,
  input dcs_pkg::dcs_cmd_e cmd,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic dqDevOe_n,
  input wire logic dqsP,
  input wire logic dqsN,
  input wire logic dqsOe_n
);
  logic singleQ;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Strobe style follows the last mode command seen on the link.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      singleQ <= dcs_pkg::STROBE_SINGLE_RST;
    end else if (cmd == dcs_pkg::CMD_MODE) begin
      singleQ <= addr[dcs_pkg::STROBE_BIT];
    end
  end
  sequence sWrite;
    cmd inside {dcs_pkg::CMD_WRITE, dcs_pkg::CMD_WRITE_AP};
  endsequence
  sequence sQuiet3;
    (cmd == dcs_pkg::CMD_NOP)[*3];
  endsequence
  a_wtr_gap: assert property (sWrite |=> (cmd != dcs_pkg::CMD_READ)[*2])
    else $error("read too soon after write");
  a_cke_hold: assert property ($changed(cke) |=> $stable(cke)[*2])
    else $error("clock enable changed too soon");
  a_down_quiet: assert property (!cke |-> cmd == dcs_pkg::CMD_NOP)
    else $error("command while clock enable low");
  a_rp_spacing: assert property (cmd == dcs_pkg::CMD_PRE |=>
    (cmd != dcs_pkg::CMD_ACT)[*3]) else $error("activate too soon");
  a_dal_spacing: assert property (cmd == dcs_pkg::CMD_WRITE_AP |=>
    (cmd != dcs_pkg::CMD_ACT)[*8]) else $error("activate before delay");
  a_xp_spacing: assert property ($rose(cke) |=> sQuiet3)
    else $error("command too soon after exit");
  a_strobe_style: assert property (!dqsOe_n |->
    dqsP && dqsN == (singleQ ? 1'h0 : !dqsP)) else $error("strobe style");
  a_read_answer: assert property (cmd == dcs_pkg::CMD_READ |=>
    !dqDevOe_n && !dqsOe_n) else $error("read data not one cycle later");
endmodule // dcs_link_properties

/* File: sim/testbench.sv */
// Testbench joining controller and device ends over one link.
// Assumes the default link widths of 14 address and 16 data bits.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic reqValid = 1'h0;
  dcs_pkg::dcs_cmd_e reqCmd = dcs_pkg::CMD_NOP;
  logic [13:0] reqAddr = '0;
  logic [15:0] reqData = '0;
  logic wrFault = 1'h0;
  logic reqReady, rdValid, ctlDown, rewritePending;
  logic devDown, strobeSingle, timingErr;
  logic [15:0] rdData;
  logic [13:0] rowAddr [4] = '{14'h0000, 14'h003F, 14'h0015, 14'h002A};
  logic [15:0] rowData [4] = '{16'h0000, 16'hFFFF, 16'hA5A5, 16'h5A5A};
  int mismatches = 0;
  int num_checks = 0;
  int n;
  always #2 clk = ~clk;
  dcs_link_if dcs_link_if_inst ();
  dcs_controller dcs_controller_inst (.clk(clk), .arst_n(arst_n),
    .reqValid(reqValid), .reqCmd(reqCmd), .reqAddr(reqAddr),
    .reqData(reqData), .reqReady(reqReady), .wrFault(wrFault),
    .rdValid(rdValid), .rdData(rdData), .poweredDown(ctlDown),
    .rewritePending(rewritePending), .link(dcs_link_if_inst.ctrl));
  dcs_device dcs_device_inst (.clk(clk), .arst_n(arst_n),
    .link(dcs_link_if_inst.dev), .poweredDown(devDown),
    .strobeSingle(strobeSingle), .timingErr(timingErr));
  dcs_link_properties dcs_link_properties_inst (.clk(clk),
    .arst_n(arst_n), .cke(dcs_link_if_inst.cke),
    .cmd(dcs_link_if_inst.cmd), .addr(dcs_link_if_inst.addr),
    .dqDevOe_n(dcs_link_if_inst.dqDevOe_n), .dqsP(dcs_link_if_inst.dqsP),
    .dqsN(dcs_link_if_inst.dqsN), .dqsOe_n(dcs_link_if_inst.dqsOe_n));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Holds the request until taken; n counts the refused edges.
  task automatic send(input dcs_pkg::dcs_cmd_e c, input logic [13:0] a,
                      input logic [15:0] d);
    n = 0;
    reqValid = 1'h1;
    reqCmd = c;
    reqAddr = a;
    reqData = d;
    @(posedge clk);
    while (reqReady !== 1'h1) begin
      n++;
      if (n > 40) begin
        mismatches++;
        end_of_test();
      end
      @(posedge clk);
    end
    #1;
  endtask

  task automatic idle(input int k);
    reqValid = 1'h0;
    reqCmd = dcs_pkg::CMD_NOP;
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic get_read(input logic [15:0] exp);
    int k;
    k = 0;
    reqValid = 1'h0;
    reqCmd = dcs_pkg::CMD_NOP;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (rdValid !== 1'h1 && k < 8);
    check(16'(k), 16'h0002);
    check(rdData, exp);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    check(16'(dcs_link_if_inst.cke), 16'h0001);
    check(16'(strobeSingle), 16'h0000);
    arst_n = 1'h1;
    for (int i = 0; i < 4; i++) begin
      send(dcs_pkg::CMD_WRITE, rowAddr[i], rowData[i]);
      send(dcs_pkg::CMD_READ, rowAddr[i], 16'h0000);
      check(16'(n), 16'h0002);
      get_read(rowData[i]);
    end
    send(dcs_pkg::CMD_PRE, 14'h0000, 16'h0000);
    send(dcs_pkg::CMD_ACT, 14'h0000, 16'h0000);
    check(16'(n), 16'h0003);
    send(dcs_pkg::CMD_WRITE_AP, 14'h0005, 16'h1234);
    send(dcs_pkg::CMD_ACT, 14'h0000, 16'h0000);
    check(16'(n), 16'h0008);
    for (int m = 1; m >= 0; m--) begin
      send(dcs_pkg::CMD_MODE, {3'h0, m[0], 10'h000}, 16'h0000);
      idle(2);
      check(16'(strobeSingle), 16'(m));
      send(dcs_pkg::CMD_READ, 14'h0005, 16'h0000);
      get_read(16'h1234);
    end
    for (int p = 0; p < 2; p++) begin
      send(dcs_pkg::CMD_PD_ENTER, 14'h0000, 16'h0000);
      check({14'h0000, devDown, ctlDown}, 16'h0001);
      if (p == 1) begin
        idle(6);
        check({14'h0000, devDown, ctlDown}, 16'h0003);
      end
      send(dcs_pkg::CMD_PD_EXIT, 14'h0000, 16'h0000);
      check(16'(n), (p == 0) ? 16'h0002 : 16'h0000);
      send(dcs_pkg::CMD_ACT, 14'h0000, 16'h0000);
      check(16'(n), 16'h0003);
    end
    send(dcs_pkg::CMD_WRITE, 14'h0009, 16'hBEEF);
    idle(1);
    wrFault = 1'h1;
    @(posedge clk);
    #1;
    wrFault = 1'h0;
    check(16'(rewritePending), 16'h0001);
    check(16'(reqReady), 16'h0000);
    @(posedge clk);
    #1;
    check(16'(dcs_link_if_inst.cmd), 16'(dcs_pkg::CMD_WRITE));
    check(16'(dcs_link_if_inst.addr), 16'h0009);
    check(dcs_link_if_inst.dqCtl, 16'hBEEF);
    send(dcs_pkg::CMD_READ, 14'h0009, 16'h0000);
    get_read(16'hBEEF);
    idle(4);
    check(16'(timingErr), 16'h0000);
    end_of_test();
  end
endmodule // testbench
